// >>> rtl/acp_axis_coupling.sv
// Axis coupling supervisor with passive referencing for a slave drive.
// Assumes one 20 MHz interpolation clock, Avalon-MM register access and
// single-cycle event pulses from the drive's own motion logic.
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "acp_defs.svh"
module acp_axis_coupling
#(
	parameter bit IS_DRIVE_B = 1'b1
)
(
	input wire logic clock,
	input wire logic arst_n,
	input acp_pkg::acp_bus_req_s bus_req,
	output acp_pkg::acp_bus_rsp_s bus_rsp,
	input acp_pkg::acp_drv_in_s drv_in,
	input wire logic [31:0] master_pos,
	input wire logic [31:0] motor_pos_delta,
	input wire logic [3:0] sources_fitted,
	input wire logic abs_encoder,
	input wire logic abs_adjusted,
	input wire logic passive_ref_request,
	output acp_pkg::acp_drv_out_s drv_out
);
	import acp_pkg::*;

	acp_state_s s;
	acp_state_s n;
	logic cfg_input;
	logic cfg_block;
	logic want_toggle;
	logic ack;

	always_comb
	begin
		n = s;
		n.rst_sync = {s.rst_sync[0], 1'b1};
		n.move_req = 1'b0;
		n.set_actual = 1'b0;
		n.readdatavalid = 1'b0;
		n.waitrequest = 1'b1;
		ack = 1'b0;
		cfg_input = (s.coupling_config == `ACP_CFG_IN_A)
			|| (s.coupling_config == `ACP_CFG_IN_B)
			|| (s.coupling_config == `ACP_CFG_IN_C);
		// Traversing-block configurations; their input terminals are ignored
		cfg_block = (s.coupling_config == `ACP_CFG_BLK_A)
			|| (s.coupling_config == `ACP_CFG_BLK_B)
			|| (s.coupling_config == `ACP_CFG_BLK_C);
		// Motor position always tracked; encoder_uses_motor stays low until the reset synchroniser has settled
		n.actual_pos = s.actual_pos + motor_pos_delta;

		// Fixed-stop and coupling interlock
		if (drv_in.fixed_stop_req)
		begin
			if (s.coupled)
			begin
				n.fault_code = `ACP_F_FIXED_STOP;
			end
			else
			begin
				n.fixed_stop_active = 1'b1;
			end
		end
		// Input 72 toggles on each rising level; fast input 73 only without ext source
		want_toggle = 1'b0;
		if (cfg_input)
		begin
			want_toggle = drv_in.couple_input && !s.couple_in_prev;
			if (drv_in.couple_fast_input && (s.position_ref_source != `ACP_SRC_EXT_A)
				&& (s.position_ref_source != `ACP_SRC_EXT_B))
			begin
				want_toggle = 1'b1;
			end
		end
		n.couple_in_prev = drv_in.couple_input;
		if (drv_in.couple_in_req && cfg_block && !s.coupled)
		begin
			want_toggle = 1'b1;
		end
		if (want_toggle)
		begin
			if (!s.coupled && s.fixed_stop_active)
			begin
				n.fault_code = `ACP_F_FIXED_STOP;
			end
			else if (!s.coupled && !sources_fitted[s.position_ref_source[1:0]]
				&& s.position_ref_source != `ACP_SRC_NONE)
			begin
				n.fault_code = `ACP_F_SRC_MISSING;
			end
			else
			begin
				if (!s.coupled)
				begin
					n.coupling_position_table0 = master_pos;
				end
				n.coupled = !s.coupled;
			end
		end
		if (s.coupled)
		begin
			if (drv_in.swl_minus_passed)
			begin
				n.fault_code = `ACP_F_SWL_MINUS;
			end
			else if (drv_in.swl_plus_passed)
			begin
				n.fault_code = `ACP_F_SWL_PLUS;
			end
			// Warnings only flag; no stop is issued so the master can react
			if (drv_in.swl_plus_predicted)
			begin
				n.warn_code = `ACP_W_SWL_PLUS;
			end
			else if (drv_in.swl_minus_predicted)
			begin
				n.warn_code = `ACP_W_SWL_MINUS;
			end
			if (drv_in.block_abs_target)
			begin
				n.fault_code = `ACP_F_ABS_TARGET;
			end
			if (drv_in.block_cont_ext && s.continue_external_mode != `ACP_CONT_EXT_OK)
			begin
				n.fault_code = `ACP_F_CONT_EXT;
			end
		end
		if (drv_in.prog_has_couple_cmd && cfg_input)
		begin
			n.fault_code = `ACP_F_PROG_CMD;
		end

		// Passive referencing sequence
		n.preq_prev = passive_ref_request;
		n.cam_prev = drv_in.ref_cam;
		case (s.ref_state)
			ACP_IDLE:
			begin
				if (passive_ref_request && !s.preq_prev)
				begin
					if (abs_encoder && !abs_adjusted)
					begin
						n.fault_code = `ACP_F_ABS_UNADJ;
					end
					else
					begin
						n.referenced = 1'b0;
						n.ref_state = ACP_CAM_SEARCH;
					end
				end
			end
			ACP_CAM_SEARCH:
			begin
				// Only a falling cam edge counts; a cam already left is not seen
				if (s.cam_prev && !drv_in.ref_cam)
				begin
					n.ref_state = ACP_ZERO_SEARCH;
				end
				else if (!passive_ref_request)
				begin
					n.fault_code = `ACP_F_NO_ZERO;
					n.ref_state = ACP_IDLE;
				end
			end
			ACP_ZERO_SEARCH:
			begin
				if (drv_in.zero_mark)
				begin
					n.zero_pos = s.actual_pos;
					n.ref_state = ACP_WAIT_MASTER;
				end
				else if (!passive_ref_request)
				begin
					n.fault_code = `ACP_F_NO_ZERO;
					n.ref_state = ACP_IDLE;
				end
			end
			ACP_WAIT_MASTER:
			begin
				if (!passive_ref_request)
				begin
					if (s.passive_ref_mode == `ACP_MODE_LEARN)
					begin
						n.reference_offset = s.actual_pos - s.zero_pos;
						n.passive_ref_mode = `ACP_MODE_TRAVEL;
						n.ref_state = ACP_IDLE;
					end
					else if (s.passive_ref_mode == `ACP_MODE_TRAVEL)
					begin
						n.ref_state = ACP_WAIT_STILL;
					end
					else
					begin
						n.set_actual = 1'b1;
						n.actual_pos = s.reference_coordinate;
						n.referenced = 1'b1;
						n.ref_state = ACP_IDLE;
					end
				end
			end
			ACP_WAIT_STILL:
			begin
				if (drv_in.standstill)
				begin
					n.move_req = 1'b1;
					n.ref_state = ACP_TRAVEL;
				end
			end
			ACP_TRAVEL:
			begin
				// Standstill after the move pulse means the own reference point is reached
				if (drv_in.standstill && !s.move_req)
				begin
					n.set_actual = 1'b1;
					n.actual_pos = s.reference_coordinate;
					n.referenced = 1'b1;
					n.ref_state = ACP_IDLE;
				end
			end
			default:
			begin
				n.ref_state = ACP_IDLE;
			end
		endcase

		// Register slave: two wait cycles, then waitrequest low for one cycle
		if ((bus_req.read || bus_req.write) && s.waitrequest && !s.busy)
		begin
			n.busy = 1'b1;
		end
		else if (s.busy)
		begin
			n.busy = 1'b0;
			n.waitrequest = 1'b0;
			n.readdatavalid = bus_req.read;
			n.readdata = 32'h0000_0000;
			if (bus_req.read)
			begin
				case (bus_req.address)
					`ACP_REG_CFG: n.readdata = {17'h0, s.position_ref_source, 2'h0,
						s.passive_ref_mode, 2'h0, s.continue_external_mode,
						s.coupling_config};
					`ACP_REG_STATUS: n.readdata = {25'h0, s.ref_state, s.referenced,
						1'b0, s.fixed_stop_active, s.coupled};
					`ACP_REG_FAULT: n.readdata = {22'h0, s.fault_code};
					`ACP_REG_WARN: n.readdata = {22'h0, s.warn_code};
					`ACP_REG_REFCOORD: n.readdata = s.reference_coordinate;
					`ACP_REG_REFOFS: n.readdata = s.reference_offset;
					`ACP_REG_SYNCVEL: n.readdata = s.sync_velocity_offset;
					`ACP_REG_TABLE0: n.readdata = s.coupling_position_table0;
					`ACP_REG_ACTPOS: n.readdata = s.actual_pos;
					default: n.readdata = 32'h0000_0000;
				endcase
			end
		end
		// Writes land only on the edge at which the master sees waitrequest low
		if (!s.waitrequest && bus_req.write)
		begin
			case (bus_req.address)
				`ACP_REG_CTRL:
				begin
					ack = bus_req.writedata[0];
					// A fixed-stop start in the same cycle wins over the clear
					if (bus_req.writedata[1] && !(drv_in.fixed_stop_req && !s.coupled))
					begin
						n.fixed_stop_active = 1'b0;
					end
				end
				`ACP_REG_CFG:
				begin
					n.coupling_config = bus_req.writedata[3:0];
					n.continue_external_mode = bus_req.writedata[5:4];
					n.passive_ref_mode = bus_req.writedata[9:8];
					if (bus_req.writedata[14:12] == `ACP_SRC_INTERNAL && !IS_DRIVE_B)
					begin
						n.position_ref_source = `ACP_SRC_NONE;
					end
					else
					begin
						n.position_ref_source = bus_req.writedata[14:12];
					end
					// A missing source is flagged when selected, not only at coupling
					if (n.position_ref_source != `ACP_SRC_NONE
						&& !sources_fitted[n.position_ref_source[1:0]])
					begin
						n.fault_code = `ACP_F_SRC_MISSING;
					end
				end
				`ACP_REG_REFCOORD: n.reference_coordinate = bus_req.writedata;
				`ACP_REG_REFOFS: n.reference_offset = bus_req.writedata;
				`ACP_REG_SYNCVEL: n.sync_velocity_offset = bus_req.writedata;
				default: ;
			endcase
		end
		// Acknowledge clears codes, but a code raised this cycle survives unless it equals the code already held
		if (ack)
		begin
			if (n.fault_code == s.fault_code)
			begin
				n.fault_code = 10'h000;
			end
			if (n.warn_code == s.warn_code)
			begin
				n.warn_code = 10'h000;
			end
		end
		// Registered so that both present outputs come straight from flip-flops
		n.fault_present = (n.fault_code != 10'h000);
		n.warning_present = (n.warn_code != 10'h000);
		// Hold all but the synchroniser until the released reset has settled
		if (!s.rst_sync[1])
		begin
			n = '0;
			n.rst_sync = {s.rst_sync[0], 1'b1};
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s <= '0;
		end
		else
		begin
			s <= n;
		end
	end

	always_comb
	begin
		bus_rsp.readdata = s.readdata;
		bus_rsp.waitrequest = s.waitrequest;
		bus_rsp.readdatavalid = s.readdatavalid;
		drv_out.coupled = s.coupled;
		drv_out.fixed_stop_active = s.fixed_stop_active;
		// Plain copies of state bits; no logic between flip-flop and pin
		drv_out.fault_present = s.fault_present;
		drv_out.warning_present = s.warning_present;
		drv_out.move_req = s.move_req;
		drv_out.move_dist = s.reference_offset;
		drv_out.move_vel = s.sync_velocity_offset;
		drv_out.set_actual = s.set_actual;
		drv_out.referenced = s.referenced;
		drv_out.encoder_uses_motor = s.rst_sync[1];
	end
endmodule

// >>> shared/acp_defs.svh
// Constants for the axis coupling supervisor: codes, configuration values, offsets.
// Included by the design and by the bench; definitions only.
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH
`define ACP_F_FIXED_STOP 10'h0ad
`define ACP_F_SWL_MINUS 10'h084
`define ACP_F_SWL_PLUS 10'h085
`define ACP_W_SWL_PLUS 10'h37b
`define ACP_W_SWL_MINUS 10'h37c
`define ACP_F_ABS_TARGET 10'h0a5
`define ACP_F_CONT_EXT 10'h0ac
`define ACP_F_PROG_CMD 10'h0a6
`define ACP_F_SRC_MISSING 10'h314
`define ACP_F_ABS_UNADJ 10'h0b0
`define ACP_F_NO_ZERO 10'h0af
`define ACP_CONT_EXT_OK 2'h2
`define ACP_CFG_IN_A 4'h1
`define ACP_CFG_IN_B 4'h2
`define ACP_CFG_IN_C 4'h7
`define ACP_CFG_BLK_A 4'h3
`define ACP_CFG_BLK_B 4'h4
`define ACP_CFG_BLK_C 4'h8
`define ACP_MODE_LOAD 2'h0
`define ACP_MODE_LEARN 2'h1
`define ACP_MODE_TRAVEL 2'h2
`define ACP_SRC_NONE 3'h0
`define ACP_SRC_INTERNAL 3'h1
`define ACP_SRC_EXT_A 3'h2
`define ACP_SRC_EXT_B 3'h3
`define ACP_REG_CTRL 4'h0
`define ACP_REG_CFG 4'h1
`define ACP_REG_STATUS 4'h2
`define ACP_REG_FAULT 4'h3
`define ACP_REG_WARN 4'h4
`define ACP_REG_REFCOORD 4'h5
`define ACP_REG_REFOFS 4'h6
`define ACP_REG_SYNCVEL 4'h7
`define ACP_REG_TABLE0 4'h8
`define ACP_REG_ACTPOS 4'h9
`endif

// >>> shared/acp_pkg.sv
// Types shared by the axis coupling supervisor and its bench.
// Numbers live in acp_defs.svh.
package acp_pkg;
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} acp_bus_req_s;
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
		logic readdatavalid;
	} acp_bus_rsp_s;
	// Requests and events from the drive's own motion logic; ref_cam, standstill and couple_input are levels, the rest one-cycle pulses
	typedef struct packed {
		logic fixed_stop_req;
		logic couple_in_req;
		logic swl_minus_passed;
		logic swl_plus_passed;
		logic swl_plus_predicted;
		logic swl_minus_predicted;
		logic block_abs_target;
		logic block_cont_ext;
		logic prog_has_couple_cmd;
		logic ref_cam;
		logic zero_mark;
		logic standstill;
		logic couple_input;
		logic couple_fast_input;
	} acp_drv_in_s;
	typedef struct packed {
		logic coupled;
		logic fixed_stop_active;
		logic fault_present;
		logic warning_present;
		logic move_req;
		logic [31:0] move_dist;
		logic [31:0] move_vel;
		logic set_actual;
		logic referenced;
		logic encoder_uses_motor;
	} acp_drv_out_s;
	typedef enum logic [2:0] {
		ACP_IDLE,
		ACP_CAM_SEARCH,
		ACP_ZERO_SEARCH,
		ACP_WAIT_MASTER,
		ACP_WAIT_STILL,
		ACP_TRAVEL
	} acp_ref_e;
	typedef struct packed {
		logic [1:0] rst_sync;
		logic coupled;
		logic fixed_stop_active;
		logic [9:0] fault_code;
		logic [9:0] warn_code;
		logic fault_present;
		logic warning_present;
		logic [3:0] coupling_config;
		logic [1:0] continue_external_mode;
		logic [2:0] position_ref_source;
		logic [1:0] passive_ref_mode;
		logic [31:0] reference_coordinate;
		logic [31:0] reference_offset;
		logic [31:0] sync_velocity_offset;
		logic [31:0] coupling_position_table0;
		logic [31:0] actual_pos;
		logic [31:0] zero_pos;
		acp_ref_e ref_state;
		logic cam_prev;
		logic preq_prev;
		logic couple_in_prev;
		logic referenced;
		logic busy;
		logic [31:0] readdata;
		logic waitrequest;
		logic readdatavalid;
		logic move_req;
		logic set_actual;
	} acp_state_s;
endpackage

// >>> sim/acp_master_model.sv
// Master drive model for passive referencing of the slave.
// Assumes the bench pulses start and sets travel, the cycles to the reference point.
`timescale 1ns/100ps
module acp_master_model
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [7:0] travel,
	output logic passive_ref_request
);
	logic [7:0] cnt;
	logic [1:0] ph;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ph <= 2'h0;
			cnt <= 8'h0;
			passive_ref_request <= 1'b0;
		end
		else if (cnt != 8'h0)
			cnt <= cnt - 8'h1;
		else if (ph == 2'h0 && start)
		begin
			// Zero mark search and braking take a few cycles
			ph <= 2'h1;
			cnt <= 8'h3;
		end
		else if (ph == 2'h1)
		begin
			ph <= 2'h2;
			cnt <= travel;
			passive_ref_request <= 1'b1;
		end
		else if (ph == 2'h2)
		begin
			ph <= 2'h0;
			passive_ref_request <= 1'b0;
		end
	end
endmodule

// >>> sim/acp_properties.sv
// Checker for the axis coupling supervisor, watching its ports only.
// Bound to every instance of the top module at the foot of this file.
`timescale 1ns/100ps
module acp_properties
(
	input wire logic clock,
	input wire logic arst_n,
	input acp_pkg::acp_bus_req_s bus_req,
	input acp_pkg::acp_drv_in_s drv_in,
	input wire logic abs_encoder,
	input wire logic abs_adjusted,
	input wire logic passive_ref_request,
	input acp_pkg::acp_drv_out_s drv_out
);
	import acp_pkg::*;
	logic ack;
	assign ack = bus_req.write && bus_req.address == 4'h0 && bus_req.writedata[0];
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	chk_enc_motor: assert property ($past(arst_n, 4) |-> drv_out.encoder_uses_motor)
		else $error("encoder output left motor values");
	chk_fs_refused: assert property (drv_out.coupled && drv_in.fixed_stop_req |->
		##[1:3] drv_out.fault_present && !drv_out.fixed_stop_active)
		else $error("fixed stop start accepted while coupled");
	chk_couple_blocked: assert property (
		drv_out.fixed_stop_active && $rose(drv_in.couple_input) |=> !drv_out.coupled [*3])
		else $error("coupling switched in during fixed stop");
	chk_swl_fault: assert property (
		drv_out.coupled && (drv_in.swl_minus_passed || drv_in.swl_plus_passed)
		|-> ##[1:3] drv_out.fault_present) else $error("passed limit not flagged");
	chk_swl_warn: assert property (
		drv_out.coupled && (drv_in.swl_plus_predicted || drv_in.swl_minus_predicted)
		|-> ##[1:3] drv_out.warning_present) else $error("predicted limit not flagged");
	chk_warn_nomove: assert property (
		$rose(drv_out.warning_present) && !passive_ref_request |-> !drv_out.move_req [*4])
		else $error("motion started on a warning");
	chk_abs_target: assert property (drv_out.coupled && drv_in.block_abs_target
		|-> ##[1:3] drv_out.fault_present) else $error("absolute target accepted");
	chk_unadj_ref: assert property (
		$rose(passive_ref_request) && abs_encoder && !abs_adjusted
		|-> ##[1:3] drv_out.fault_present) else $error("unadjusted encoder referenced");
	chk_set_ref: assert property (drv_out.set_actual |-> ##[0:1] drv_out.referenced)
		else $error("actual value loaded without referenced");
	chk_code_hold: assert property (
		drv_out.fault_present && !ack && !$past(ack) |=> drv_out.fault_present)
		else $error("fault dropped without acknowledge");
	cover property (drv_out.coupled && drv_in.fixed_stop_req);
	cover property ($fell(passive_ref_request));
	cover property (drv_out.set_actual);
	cover property (drv_out.move_req);
endmodule
bind acp_axis_coupling acp_properties chk_i (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
	.drv_in(drv_in), .abs_encoder(abs_encoder), .abs_adjusted(abs_adjusted),
	.passive_ref_request(passive_ref_request), .drv_out(drv_out));

// >>> sim/tb.sv
// Self-checking bench for the axis coupling supervisor.
// Drives the register bus and drive events; the master model makes the request.
`timescale 1ns/100ps
`include "acp_defs.svh"
module tb;
	import acp_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	acp_bus_req_s req = '0;
	acp_bus_rsp_s rsp;
	acp_drv_in_s din = '0;
	acp_drv_out_s dout;
	logic [31:0] mpos = 32'h0;
	logic [3:0] fitted = 4'h3;
	logic abs_enc = 1'b0;
	logic abs_adj = 1'b0;
	logic prq;
	logic mstart = 1'b0;
	logic [31:0] rdv;
	int miscompares = 0;
	int checked = 0;
	always #25 clock = ~clock;
	// Motor increments tied to zero so a loaded actual value stays put
	acp_axis_coupling DUT (.clock(clock), .arst_n(arst_n), .bus_req(req), .bus_rsp(rsp),
		.drv_in(din), .master_pos(mpos), .motor_pos_delta(32'h0), .sources_fitted(fitted),
		.abs_encoder(abs_enc), .abs_adjusted(abs_adj), .passive_ref_request(prq), .drv_out(dout));
	acp_master_model master (.clock(clock), .arst_n(arst_n), .start(mstart), .travel(8'h20),
		.passive_ref_request(prq));
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
		int n;
		n = 0;
		req <= '{address: a, read: !w, write: w, writedata: d};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (rsp.waitrequest !== 1'b0 && n < 20);
		rdv = rsp.readdata;
		chk(rsp.readdatavalid, !w);
		req <= '0;
		@(posedge clock);
		if (n >= 20)
		begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic pulse(int b);
		din[b] <= 1'b1;
		@(posedge clock);
		din[b] <= 1'b0;
		@(posedge clock);
	endtask
	task automatic code(logic [3:0] a, logic [9:0] exp);
		repeat (3) @(posedge clock);
		bus(1'b0, a, 32'h0);
		chk(rdv, {22'h0, exp});
		chk(a == `ACP_REG_FAULT ? dout.fault_present : dout.warning_present, 32'h1);
		bus(1'b1, `ACP_REG_CTRL, 32'h1);
	endtask
	task automatic t_pref(int k, logic [9:0] exp);
		int n;
		n = 0;
		abs_enc <= (k == 2 || k == 0);
		abs_adj <= (k == 0);
		mstart <= 1'b1;
		@(posedge clock);
		mstart <= 1'b0;
		while (prq !== 1'b1 && n < 50)
		begin
			@(posedge clock);
			n++;
		end
		// Cam 1/0 edge, then the zero mark (skipped in test 1) while the master travels
		pulse(4);
		if (k != 1)
			pulse(3);
		while (prq !== 1'b0 && n < 100)
		begin
			@(posedge clock);
			n++;
		end
		chk(n < 100, 32'h1);
		repeat (4) @(posedge clock);
		abs_enc <= 1'b0;
		abs_adj <= 1'b0;
		if (k == 4)
		begin
			din[2] <= 1'b1;
			repeat (2) @(posedge clock);
			chk(dout.move_req, 32'h1);
			chk(dout.move_dist, 32'h40);
			chk(dout.move_vel, 32'h8);
			repeat (2) @(posedge clock);
			din[2] <= 1'b0;
		end
		if (k == 0 || k == 4)
		begin
			chk(dout.referenced, 32'h1);
			bus(1'b0, `ACP_REG_ACTPOS, 32'h0);
			chk(rdv, k == 0 ? 32'h500 : 32'h700);
		end
		else if (k != 3)
			code(`ACP_REG_FAULT, exp);
		$display("referencing test %0d done", k);
	endtask
	task automatic t_setup();
		chk(dout.encoder_uses_motor, 32'h1);
		bus(1'b1, 4'hf, 32'h5a5a);
		bus(1'b0, 4'hf, 32'h0);
		chk(rdv, 32'h0);
		bus(1'b1, `ACP_REG_CFG, 32'h2001);
		code(`ACP_REG_FAULT, `ACP_F_SRC_MISSING);
		fitted <= 4'hf;
		bus(1'b1, `ACP_REG_CFG, 32'h2001);
		pulse(0);
		chk(dout.coupled, 32'h0);
		bus(1'b1, `ACP_REG_CFG, 32'h0001);
		pulse(13);
		chk(dout.fixed_stop_active, 32'h1);
		pulse(1);
		code(`ACP_REG_FAULT, `ACP_F_FIXED_STOP);
		chk(dout.coupled, 32'h0);
		bus(1'b1, `ACP_REG_CTRL, 32'h2);
		bus(1'b1, `ACP_REG_CFG, 32'h0003);
		pulse(1);
		chk(dout.coupled, 32'h0);
		$display("setup test done");
	endtask
	task automatic t_coupled();
		int bits[6] = '{13, 11, 10, 7, 6, 5};
		logic [9:0] codes[6] = '{`ACP_F_FIXED_STOP, `ACP_F_SWL_MINUS, `ACP_F_SWL_PLUS,
			`ACP_F_ABS_TARGET, `ACP_F_CONT_EXT, `ACP_F_PROG_CMD};
		bus(1'b1, `ACP_REG_CFG, 32'h0001);
		mpos <= 32'h00abcdef;
		pulse(1);
		chk(dout.coupled, 32'h1);
		bus(1'b0, `ACP_REG_TABLE0, 32'h0);
		chk(rdv, 32'h00abcdef);
		for (int i = 0; i < 6; i++)
		begin
			if (dout.coupled !== 1'b1)
				pulse(1);
			pulse(bits[i]);
			code(`ACP_REG_FAULT, codes[i]);
		end
		for (int i = 0; i < 2; i++)
		begin
			pulse(9 - i);
			chk(dout.move_req, 32'h0);
			code(`ACP_REG_WARN, i == 0 ? `ACP_W_SWL_PLUS : `ACP_W_SWL_MINUS);
		end
		bus(1'b1, `ACP_REG_CFG, 32'h0021);
		pulse(6);
		repeat (3) @(posedge clock);
		chk(dout.fault_present, 32'h0);
		$display("coupled test done");
	endtask
	initial
	begin
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_setup();
		t_coupled();
		bus(1'b1, `ACP_REG_REFCOORD, 32'h500);
		// Absolute encoder slave in tests 2 and 0, so mode 0 is a legal choice here
		bus(1'b1, `ACP_REG_CFG, 32'h0001);
		t_pref(1, `ACP_F_NO_ZERO);
		t_pref(2, `ACP_F_ABS_UNADJ);
		t_pref(0, 10'h0);
		bus(1'b1, `ACP_REG_CFG, 32'h0101);
		t_pref(3, 10'h0);
		bus(1'b0, `ACP_REG_CFG, 32'h0);
		chk(rdv[9:8], 32'h2);
		bus(1'b1, `ACP_REG_REFCOORD, 32'h700);
		bus(1'b1, `ACP_REG_REFOFS, 32'h40);
		bus(1'b1, `ACP_REG_SYNCVEL, 32'h8);
		t_pref(4, 10'h0);
		end_sim();
	end
endmodule
